// File: inc/rsq_pkg.sv
// Shared constants for the reset sequencer and prescaler
package rsq_pkg;
  // Fast base clock rate
  localparam int CLOCK_MHZ = 25;
  // Power-on and low-voltage stabilisation count
  localparam int POR_CYCLES = 4096;
  // Active pin drive and internal hold after it
  localparam int PIN_DRIVE_CYCLES = 32;
  localparam int HOLD_CYCLES = 32;
  // Vector fetch lead-in before the CPU runs
  localparam int FETCH_CYCLES = 3;
  // Whole recovery lengths
  localparam int POR_RECOVERY_CYCLES = POR_CYCLES + PIN_DRIVE_CYCLES + HOLD_CYCLES + FETCH_CYCLES;
  localparam int OTHER_RECOVERY_CYCLES = PIN_DRIVE_CYCLES + HOLD_CYCLES + FETCH_CYCLES;
  // Stop recovery delays
  localparam int STOP_SHORT_CYCLES = 32;
  localparam int STOP_LONG_CYCLES = 4096;
  // Prescaler layout: twelve stages, service clears stages 12 to 5
  localparam int PRESCALE_BITS = 12;
  localparam int SERVICE_CLR_LO = 4;
  localparam int SERVICE_CLR_HI = 11;
  // Longest gap between two watchdog clocks
  localparam int TAP_MAX_CYCLES = 4096;
  // Watchdog service address
  localparam logic [15:0] SERVICE_ADDR = 16'hFFFF;
  // Least external reset pulse, in ns, and in cycles rounded up
  localparam int T_RL_NS = 100;
  localparam int RL_CYCLES = (T_RL_NS * CLOCK_MHZ + 999) / 1000;
  // Cause flag positions
  localparam int CAUSE_W = 6;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_BAD_OP = 3;
  localparam int CAUSE_BAD_FETCH = 4;
  localparam int CAUSE_LOW_V = 5;
  localparam logic [5:0] CAUSE_RESET = 6'h00;
  // Watchdog depth
  localparam int WDOG_BITS = 6;
  // Sequencer states
  typedef enum logic [7:0] {
    ST_POR_WAIT = 8'h01,
    ST_PIN_DRIVE = 8'h02,
    ST_HOLD = 8'h04,
    ST_FETCH = 8'h08,
    ST_EXT = 8'h10,
    ST_RUN = 8'h20,
    ST_STOP = 8'h40,
    ST_STOP_REC = 8'h80
  } rsq_state_t;
endpackage

// File: verilog/rsq_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for asynchronous inputs
module rsq_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input logic i_clock,
  input logic i_rst,
  // Raw and synchronised levels
  input logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  // First stage, read only by the second
  logic [W-1:0] meta;

  // Two stages in series
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // rsq_sync

// File: verilog/rsq_counter.sv
`timescale 1ns/1ns
// Free-running prescaler with full and partial clear
module rsq_counter #(
  parameter int BITS = rsq_pkg::PRESCALE_BITS
) (
  // Clock and reset
  input logic i_clock,
  input logic i_rst,
  // Clear controls
  input logic i_clear_all,
  input logic i_clear_upper,
  // Count and all-ones tap
  output logic [BITS-1:0] o_count,
  output logic o_tap
);
  // Mask of the stages a service write clears
  localparam logic [BITS-1:0] UPPER_MASK =
    BITS'(((1 << (rsq_pkg::SERVICE_CLR_HI + 1)) - 1) & ~((1 << rsq_pkg::SERVICE_CLR_LO) - 1));
  // Incremented value
  logic [BITS-1:0] next_count;

  // Next count: advance, then drop the upper stages on service
  always_comb begin
    next_count = o_count + 1'b1;
    if (i_clear_upper) begin
      next_count = next_count & ~UPPER_MASK;
    end
  end

  assign o_tap = &o_count;

  always_ff @(posedge i_clock) begin
    if (i_rst || i_clear_all) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end
endmodule // rsq_counter

// File: verilog/rsq_top.sv
`timescale 1ns/1ns
module rsq_top #(
  parameter int WDOG_BITS = rsq_pkg::WDOG_BITS
) (
  // Clock and reset
  input logic i_clock,
  input logic i_rst,
  // Asynchronous reset sources
  input logic i_power_on_pulse,
  input logic i_low_voltage_trip,
  // CPU decode signals
  input logic i_bad_opcode,
  input logic i_opcode_fetch,
  input logic i_unmapped_addr,
  input logic i_stop_exec,
  input logic i_stop_wake,
  // Internal bus write
  input logic i_bus_write,
  input logic [15:0] i_bus_addr,
  // Configuration bits
  input logic i_reset_pin_enable,
  input logic i_short_stop_recovery,
  input logic i_stop_enable,
  input logic i_break_monitor,
  input logic i_break_disables_watchdog,
  input logic i_cause_clear,
  // Reset pin, open drain
  input logic i_reset_pin,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe_n,
  output logic o_reset_pin_level,
  // Status
  output logic o_internal_reset_signal,
  output logic o_cpu_release,
  output logic o_clocks_active,
  output logic o_osc_enable,
  output logic o_watchdog_tick,
  output logic [5:0] o_reset_cause_register
);
  // Last cycle indices of the short phases and stop delays, and the least pin-low count
  localparam logic [5:0] PIN_LAST = 6'(rsq_pkg::PIN_DRIVE_CYCLES - 1);
  localparam logic [5:0] HOLD_LAST = 6'(rsq_pkg::HOLD_CYCLES - 1);
  localparam logic [5:0] FETCH_LAST = 6'(rsq_pkg::FETCH_CYCLES - 1);
  localparam logic [11:0] STOP_SHORT_LAST = 12'(rsq_pkg::STOP_SHORT_CYCLES - 1);
  localparam logic [11:0] STOP_LONG_LAST = 12'(rsq_pkg::STOP_LONG_CYCLES - 1);
  localparam logic [7:0] RL_COUNT = 8'(rsq_pkg::RL_CYCLES);

  // Sequencer state
  rsq_pkg::rsq_state_t st;
  rsq_pkg::rsq_state_t next_st;
  // Phase length counter
  logic [5:0] dly;
  // Cycles the pin has been held low from outside
  logic [7:0] pin_low;
  // Watchdog counter
  logic [WDOG_BITS-1:0] wdog;
  // Synchronised pin, power-on and low-voltage levels
  logic [2:0] sync_out;
  logic pin_s;
  logic por_s;
  logic lvi_s;
  // Prescaler view
  logic [11:0] cnt;
  logic tap;
  logic clr_all;
  // Decoded events
  logic por_held;
  logic bad_op;
  logic bad_fetch;
  logic service;
  logic wdog_run;
  logic wdog_ovf;
  logic int_src;
  logic pin_evt;
  logic awake;
  logic [5:0] cause_set;
  logic [11:0] stop_last;

  // Pin idles high, sources idle low
  rsq_sync #(
    .W(3),
    .INIT(3'h4)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_reset_pin, i_power_on_pulse, i_low_voltage_trip}),
    .o_sync(sync_out)
  );

  // Split synchronised levels
  assign pin_s = sync_out[2];
  assign por_s = sync_out[1];
  assign lvi_s = sync_out[0];

  // Prescaler shared by reset, stop and watchdog
  rsq_counter #(
    .BITS(rsq_pkg::PRESCALE_BITS)
  ) u_cnt (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear_all(clr_all),
    .i_clear_upper(service),
    .o_count(cnt),
    .o_tap(tap)
  );

  // Source decode
  always_comb begin
    // Power-on or supply low, held as a level
    por_held = por_s | lvi_s;
    bad_op = i_bad_opcode | (i_stop_exec & ~i_stop_enable);
    bad_fetch = i_opcode_fetch & i_unmapped_addr;
    // CPU is in a running or stopped state
    awake = (st == rsq_pkg::ST_RUN) | (st == rsq_pkg::ST_STOP) | (st == rsq_pkg::ST_STOP_REC);
    service = i_bus_write & (i_bus_addr == rsq_pkg::SERVICE_ADDR) & (st == rsq_pkg::ST_RUN);
    wdog_run = (st == rsq_pkg::ST_RUN) & ~(i_break_monitor & i_break_disables_watchdog);
    // overflow on the tick past all ones
    wdog_ovf = wdog_run & tap & (&wdog) & ~service;
    // Internal sources seen while running
    int_src = (st == rsq_pkg::ST_RUN) & (bad_op | bad_fetch | wdog_ovf);
    pin_evt = i_reset_pin_enable & ~pin_s & awake;
    stop_last = i_short_stop_recovery ? STOP_SHORT_LAST : STOP_LONG_LAST;
  end

  // Next state
  always_comb begin
    next_st = st;
    case (st)
      rsq_pkg::ST_POR_WAIT: begin
        if (!por_held && tap) begin
          next_st = rsq_pkg::ST_PIN_DRIVE;
        end
      end
      rsq_pkg::ST_PIN_DRIVE: begin
        if (dly == PIN_LAST) begin
          next_st = rsq_pkg::ST_HOLD;
        end
      end
      rsq_pkg::ST_HOLD: begin
        if (dly == HOLD_LAST) begin
          next_st = rsq_pkg::ST_FETCH;
        end
      end
      rsq_pkg::ST_FETCH: begin
        if (dly == FETCH_LAST) begin
          next_st = rsq_pkg::ST_RUN;
        end
      end
      rsq_pkg::ST_EXT: begin
        if (pin_s) begin
          next_st = rsq_pkg::ST_HOLD;
        end
      end
      // Running: internal fault or stop entry
      rsq_pkg::ST_RUN: begin
        if (int_src) begin
          next_st = rsq_pkg::ST_PIN_DRIVE;
        end else if (i_stop_exec) begin
          next_st = rsq_pkg::ST_STOP;
        end
      end
      // Stopped until a wake-up
      rsq_pkg::ST_STOP: begin
        if (i_stop_wake) begin
          next_st = rsq_pkg::ST_STOP_REC;
        end
      end
      rsq_pkg::ST_STOP_REC: begin
        if (cnt == stop_last) begin
          next_st = rsq_pkg::ST_RUN;
        end
      end
      default: begin
        next_st = rsq_pkg::ST_POR_WAIT;
      end
    endcase
    // Outside pin wins over the running sources
    if (pin_evt) begin
      next_st = rsq_pkg::ST_EXT;
    end
    // supply trip restarts the long wait
    if (por_held) begin
      next_st = rsq_pkg::ST_POR_WAIT;
    end
  end

  // clear on power-on, internal reset, stop, wake
  // Clearing on the wake edge as well gives the stop delay its full length
  assign clr_all = por_held
    | ((next_st == rsq_pkg::ST_PIN_DRIVE) & (st != rsq_pkg::ST_POR_WAIT))
    | (next_st == rsq_pkg::ST_STOP)
    | (st == rsq_pkg::ST_STOP);

  // State register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st <= rsq_pkg::ST_POR_WAIT;
    end else begin
      st <= next_st;
    end
  end

  // Phase counter restarts on each state change
  always_ff @(posedge i_clock) begin
    if (i_rst || next_st != st) begin
      dly <= 6'h00;
    end else begin
      dly <= dly + 6'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || st != rsq_pkg::ST_EXT) begin
      pin_low <= 8'h01;
    end else if (pin_low != 8'hFF) begin
      pin_low <= pin_low + 8'h01;
    end
  end

  // Watchdog counter, held clear while the CPU is in reset
  always_ff @(posedge i_clock) begin
    if (i_rst || st != rsq_pkg::ST_RUN || service) begin
      wdog <= '0;
    end else if (wdog_run && tap) begin
      wdog <= wdog + 1'b1;
    end
  end

  always_comb begin
    cause_set = 6'h00;
    cause_set[rsq_pkg::CAUSE_LOW_V] = lvi_s;
    cause_set[rsq_pkg::CAUSE_PIN] = (st == rsq_pkg::ST_EXT) & (pin_low == RL_COUNT);
    if ((st == rsq_pkg::ST_RUN) && !pin_evt && !por_held) begin
      cause_set[rsq_pkg::CAUSE_WDOG] = wdog_ovf;
      cause_set[rsq_pkg::CAUSE_BAD_OP] = bad_op;
      cause_set[rsq_pkg::CAUSE_BAD_FETCH] = bad_fetch;
    end
  end

  // Cause register: power-on leaves only its own flag, sets beat clears
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_reset_cause_register <= rsq_pkg::CAUSE_RESET;
    end else if (por_s) begin
      o_reset_cause_register <= 6'h01 << rsq_pkg::CAUSE_POR;
    end else if (i_cause_clear) begin
      o_reset_cause_register <= cause_set;
    end else begin
      o_reset_cause_register <= o_reset_cause_register | cause_set;
    end
  end

  // Output flops, aligned with the state register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_internal_reset_signal <= 1'b1;
      o_cpu_release <= 1'b0;
      o_clocks_active <= 1'b0;
      o_osc_enable <= 1'b0;
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe_n <= 1'b1;
      o_watchdog_tick <= 1'b0;
    end else begin
      // reset held until running or stopped
      o_internal_reset_signal <= ~((next_st == rsq_pkg::ST_RUN)
        | (next_st == rsq_pkg::ST_STOP) | (next_st == rsq_pkg::ST_STOP_REC));
      o_cpu_release <= next_st == rsq_pkg::ST_RUN;
      o_clocks_active <= ~((next_st == rsq_pkg::ST_POR_WAIT)
        | (next_st == rsq_pkg::ST_STOP) | (next_st == rsq_pkg::ST_STOP_REC));
      o_osc_enable <= 1'b1;
      o_reset_pin_out <= 1'b0;
      // drive pin low through the wait and drive phases
      o_reset_pin_oe_n <= ~(i_reset_pin_enable & ((next_st == rsq_pkg::ST_POR_WAIT)
        | (next_st == rsq_pkg::ST_PIN_DRIVE)));
      o_watchdog_tick <= tap;
    end
  end

  // Pin level for general-purpose use
  assign o_reset_pin_level = pin_s;

  // Helper: cycles since the recovery sequence began
  logic [12:0] rec_cnt;
  logic ext_path;
  logic [12:0] tap_gap;

  // Recovery length counter for checks
  always_ff @(posedge i_clock) begin
    if (i_rst || awake || por_held) begin
      rec_cnt <= 13'h0000;
    end else begin
      rec_cnt <= rec_cnt + 13'h0001;
    end
  end

  // Remembers whether recovery started from the pin
  always_ff @(posedge i_clock) begin
    if (i_rst || por_held || int_src) begin
      ext_path <= 1'b0;
    end else if (st == rsq_pkg::ST_EXT) begin
      ext_path <= 1'b1;
    end
  end

  // Cycles since the last tap
  always_ff @(posedge i_clock) begin
    if (i_rst || tap || clr_all || service) begin
      tap_gap <= 13'h0001;
    end else begin
      tap_gap <= tap_gap + 13'h0001;
    end
  end

  // Reset seen at the last edge, keeps checks off the first edge out of reset
  logic rst_q;

  // Delayed reset for the check guard
  always_ff @(posedge i_clock) begin
    rst_q <= i_rst;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || rst_q);

  // Running with an internal source present
  sequence s_int_event;
    (st == rsq_pkg::ST_RUN) && int_src && !pin_evt && !por_held;
  endsequence

  // Reset sequence entered, counter at zero
  sequence s_seq_start;
    o_internal_reset_signal && (cnt == 12'h000);
  endsequence

  int_reset_a: assert property (s_int_event |=> s_seq_start)
    else $error("internal source did not start reset");

  ext_counter_a: assert property ((st == rsq_pkg::ST_RUN) && pin_evt && !por_held && !service
    |=> (st == rsq_pkg::ST_EXT) && (cnt == $past(cnt) + 12'h001))
    else $error("pin reset disturbed counter");

  pin_flag_a: assert property ((st == rsq_pkg::ST_EXT) && (pin_low == RL_COUNT) && !por_s
    |=> o_reset_cause_register[rsq_pkg::CAUSE_PIN])
    else $error("pin flag not set");

  pin_gate_a: assert property (!i_reset_pin_enable |=> o_reset_pin_oe_n)
    else $error("pin driven while disabled");

  por_drive_a: assert property ((st == rsq_pkg::ST_POR_WAIT) && i_reset_pin_enable
    |=> !o_reset_pin_oe_n)
    else $error("pin not low during wait");

  drive_len_a: assert property ($rose(st == rsq_pkg::ST_PIN_DRIVE) && i_reset_pin_enable
    && !por_held |-> ##31 (!o_reset_pin_oe_n || por_held) ##1 o_reset_pin_oe_n)
    else $error("active drive length wrong");

  recovery_len_a: assert property ($rose(o_cpu_release) && $past(o_internal_reset_signal)
    && !ext_path |->
    (rec_cnt == 13'(rsq_pkg::POR_RECOVERY_CYCLES))
    || (rec_cnt == 13'(rsq_pkg::OTHER_RECOVERY_CYCLES)))
    else $error("recovery length wrong");

  por_clocks_a: assert property (por_held |=> !o_clocks_active && o_internal_reset_signal
    && (o_reset_cause_register[rsq_pkg::CAUSE_POR] || !$past(por_s)))
    else $error("power-on clocks or flag wrong");

  bad_op_a: assert property (s_int_event and (i_stop_exec && !i_stop_enable)
    |=> o_reset_cause_register[rsq_pkg::CAUSE_BAD_OP])
    else $error("illegal stop not flagged");

  wdog_flag_a: assert property (s_int_event and wdog_ovf
    |=> o_reset_cause_register[rsq_pkg::CAUSE_WDOG])
    else $error("watchdog overflow not flagged");

  data_access_a: assert property ((st == rsq_pkg::ST_RUN) && i_unmapped_addr && !i_opcode_fetch
    && !bad_op && !wdog_ovf && !pin_evt && !por_held && !i_stop_exec
    |=> o_cpu_release)
    else $error("data access caused reset");

  service_a: assert property (service && !por_held && !pin_evt
    |=> (wdog == '0) && (cnt[11:4] == 8'h00))
    else $error("service did not clear");

  freeze_a: assert property ((st == rsq_pkg::ST_RUN) && i_break_monitor
    && i_break_disables_watchdog && !service |=> wdog == $past(wdog))
    else $error("watchdog ran during break");

  tap_gap_a: assert property (tap_gap <= 13'(rsq_pkg::TAP_MAX_CYCLES))
    else $error("prescaler tap too late");

  stop_clear_a: assert property ((st == rsq_pkg::ST_RUN) && i_stop_exec && i_stop_enable
    && !int_src && !pin_evt && !por_held |=> cnt == 12'h000)
    else $error("stop did not clear counter");

  stop_short_a: assert property ($rose(st == rsq_pkg::ST_STOP_REC) && i_short_stop_recovery
    |-> ##31 !o_cpu_release
    ##1 (o_cpu_release || o_internal_reset_signal || !i_short_stop_recovery))
    else $error("short stop recovery wrong");

  count_step_a: assert property (!clr_all && !service && !por_held
    |=> cnt == $past(cnt) + 12'h001)
    else $error("counter missed an edge");
endmodule // rsq_top

// File: verification/rsq_pin_model.sv
`timescale 1ns/1ns
// Far-side chip on the shared reset line, with the line's pull-up
module rsq_pin_model (
  // Clock
  input logic i_clock,
  // Device drive and far-side request
  input logic i_dev_out,
  input logic i_dev_oe_n,
  input logic i_pull_req,
  // Resolved line level
  output logic o_line
);
  // Cycles the far side has held the line low
  int held = 0;
  // Far side is pulling the line low
  logic pulling = 1'b0;

  always @(posedge i_clock) begin
    if (i_pull_req || (pulling && held < rsq_pkg::RL_CYCLES)) begin
      pulling <= 1'b1;
      held <= held + 1;
    end else begin
      pulling <= 1'b0;
      held <= 0;
    end
  end

  // Pull-up wins when nobody drives low
  assign o_line = ((i_dev_oe_n === 1'b0 && i_dev_out === 1'b0) || pulling) ? 1'b0 : 1'b1;
endmodule // rsq_pin_model

// File: verification/rsq_top_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the reset sequencer
module rsq_top_tb_top;
  `define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
  // Short watchdog so an overflow fits the run
  localparam int WB = 2;
  // Stimulus
  logic i_clock = 1'b0, i_rst = 1'b1, pon = 1'b1, lvt = 1'b0, bad_op = 1'b0, fetch = 1'b0;
  logic unmap = 1'b0, stop_x = 1'b0, wake = 1'b0, bus_wr = 1'b0, pin_en = 1'b1, ssr = 1'b0;
  logic stop_en = 1'b0, brk = 1'b0, brk_dis = 1'b0, cclr = 1'b0, pull = 1'b0, first, ok;
  logic [15:0] bus_addr = 16'h0000;
  // Observed
  logic line, pin_out, pin_oe_n, pin_lvl, internal_reset_signal, rel, clk_on, osc, tick;
  logic [5:0] cause;
  int err_count = 0, num_checks = 0, n, lo, k;

  // Clock
  always #20 i_clock = ~i_clock;

  rsq_top #(.WDOG_BITS(WB)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_power_on_pulse(pon), .i_low_voltage_trip(lvt),
    .i_bad_opcode(bad_op), .i_opcode_fetch(fetch), .i_unmapped_addr(unmap),
    .i_stop_exec(stop_x), .i_stop_wake(wake), .i_bus_write(bus_wr), .i_bus_addr(bus_addr),
    .i_reset_pin_enable(pin_en), .i_short_stop_recovery(ssr), .i_stop_enable(stop_en),
    .i_break_monitor(brk), .i_break_disables_watchdog(brk_dis), .i_cause_clear(cclr),
    .i_reset_pin(line), .o_reset_pin_out(pin_out), .o_reset_pin_oe_n(pin_oe_n),
    .o_reset_pin_level(pin_lvl), .o_internal_reset_signal(internal_reset_signal), .o_cpu_release(rel),
    .o_clocks_active(clk_on), .o_osc_enable(osc), .o_watchdog_tick(tick),
    .o_reset_cause_register(cause));

  rsq_pin_model u_pin (.i_clock(i_clock), .i_dev_out(pin_out), .i_dev_oe_n(pin_oe_n),
    .i_pull_req(pull), .o_line(line));

  // Wait some edges
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clock);
  endtask

  // Count cycles until release or clocks, and cycles of pin drive
  task automatic measure(input bit use_clk);
    n = 0;
    lo = 0;
    #1;
    first = internal_reset_signal;
    while (((use_clk ? clk_on : rel) !== 1'b1) && n < 9000) begin
      if (pin_oe_n === 1'b0) lo++;
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask

  // Count cycles until the next watchdog tick
  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 5000);
  endtask

  // One-cycle strobe; returns at the edge that takes it
  task automatic pulse(input int sel);
    @(posedge i_clock);
    case (sel)
      0: bad_op <= 1'b1;
      1: begin fetch <= 1'b1; unmap <= 1'b1; end
      2: stop_x <= 1'b1;
      3: wake <= 1'b1;
      4: cclr <= 1'b1;
      default: begin bus_wr <= 1'b1; bus_addr <= rsq_pkg::SERVICE_ADDR; end
    endcase
    @(posedge i_clock);
    {bad_op, fetch, unmap, stop_x, wake, cclr, bus_wr} <= '0;
  endtask

  // Long recovery after power-on or low voltage drops
  task automatic slow;
    cyc(100);
    #1;
    `CHK("reset held", 1'b1, internal_reset_signal)
    `CHK("clocks held", 1'b0, clk_on)
    `CHK("osc", 1'b1, osc)
    `CHK("pin driven", 1'b0, pin_oe_n)
    `CHK("pin out", 1'b0, pin_out)
    measure(0);
    n = n + 100;
    ok = n >= rsq_pkg::POR_RECOVERY_CYCLES && n <= rsq_pkg::POR_RECOVERY_CYCLES + 6;
    `CHK("long recovery", 1'b1, ok)
    ok = lo + 100 >= rsq_pkg::POR_CYCLES + rsq_pkg::PIN_DRIVE_CYCLES;
    `CHK("long drive", 1'b1, ok)
  endtask

  // Internal source after random traffic and a data access
  task automatic internal(input int sel, input logic [5:0] exp);
    repeat ($urandom_range(1, 20)) begin
      @(posedge i_clock);
      bus_wr <= 1'b1;
      bus_addr <= 16'($urandom) & 16'hFFFE;
    end
    pulse(5);
    pulse(4);
    @(posedge i_clock);
    unmap <= 1'b1;
    cyc(3);
    unmap <= 1'b0;
    #1;
    `CHK("data access", 1'b0, internal_reset_signal)
    pulse(sel);
    measure(0);
    `CHK("reset", 1'b1, first)
    `CHK("recovery", rsq_pkg::OTHER_RECOVERY_CYCLES, n)
    `CHK("drive", rsq_pkg::PIN_DRIVE_CYCLES, lo)
    `CHK("cause", exp, cause)
  endtask

  // Verdict
  task automatic results;
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    cyc(95000);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(56008));
    cyc(2);
    i_rst <= 1'b0;
    cyc(4);
    pon <= 1'b0;
    slow();
    `CHK("por cause", 6'h01, cause)
    // Pin as plain input while disabled
    @(posedge i_clock);
    pin_en <= 1'b0;
    pull <= 1'b1;
    cyc(6);
    pull <= 1'b0;
    #1;
    `CHK("pin off", 1'b0, internal_reset_signal)
    `CHK("pin level", 1'b0, pin_lvl)
    cyc(4);
    pin_en <= 1'b1;
    cyc(3);
    for (int i = 0; i < 6; i++) begin
      k = (i < 3) ? i : $urandom_range(0, 2);
      internal(k, (k == 1) ? 6'h10 : 6'h08);
    end
    // External pin reset
    pulse(4);
    @(posedge i_clock);
    pull <= 1'b1;
    cyc(10);
    #1;
    `CHK("halt", 1'b1, internal_reset_signal)
    @(posedge i_clock);
    pull <= 1'b0;
    measure(0);
    ok = n >= 35 && n <= 39;
    `CHK("pin recovery", 1'b1, ok)
    `CHK("no drive", 0, lo)
    `CHK("pin cause", 6'h02, cause)
    // Low voltage
    pulse(4);
    @(posedge i_clock);
    lvt <= 1'b1;
    cyc($urandom_range(10, 40));
    lvt <= 1'b0;
    slow();
    `CHK("lv cause", 6'h20, cause)
    // Stop with short then long recovery
    @(posedge i_clock);
    stop_en <= 1'b1;
    ssr <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      pulse(2);
      cyc(3);
      #1;
      `CHK("stopped", 1'b0, clk_on)
      pulse(3);
      measure(1);
      k = (i == 0) ? rsq_pkg::STOP_SHORT_CYCLES : rsq_pkg::STOP_LONG_CYCLES;
      ok = n >= k && n <= k + 2;
      `CHK("stop recovery", 1'b1, ok)
      ssr <= 1'b0;
    end
    stop_en <= 1'b0;
    // Tick spacing
    pulse(5);
    wait_tick();
    wait_tick();
    `CHK("tick gap", rsq_pkg::TAP_MAX_CYCLES, n)
    // Servicing keeps the watchdog quiet
    pulse(4);
    repeat (7) begin
      cyc(2900);
      pulse(5);
    end
    #1;
    `CHK("serviced", 6'h00, cause)
    // Break with disable freezes the watchdog
    @(posedge i_clock);
    brk <= 1'b1;
    brk_dis <= 1'b1;
    cyc(17000);
    #1;
    `CHK("frozen", 1'b0, internal_reset_signal)
    @(posedge i_clock);
    brk_dis <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (internal_reset_signal !== 1'b1 && n < 20000);
    ok = n >= 3 * rsq_pkg::TAP_MAX_CYCLES && n <= 4 * rsq_pkg::TAP_MAX_CYCLES + 16;
    `CHK("overflow", 1'b1, ok)
    measure(0);
    `CHK("wdog cause", 6'h04, cause)
    results();
  end
endmodule // rsq_top_tb_top
